// ---- hw/nlts_core.sv ----
// nibble logic and test-skip unit with its wishbone register slave
//
// What this block does
// - and, or and xor work bit by bit on the two nibbles with the usual truth tables.
// - logic ops leave carry and zero alone and ignore the decimal and compare-only flags.
// - skip_if_all_set skips the next instruction when every masked memory bit is one.
// - skip_if_all_clear skips the next instruction when every masked memory bit is zero.
// - the bit tests only take a memory operand and have no register form.
// - either bit test clears the compare-only flag.
// - the bit tests ignore decimal mode and never touch carry or zero.
// - with index enable set the memory address is offset by the index before the read.
// - the compare-skip ops compare a memory nibble with an immediate only.
// - skip_if_equal skips when the nibble equals the immediate.
// - skip_if_unequal skips when the nibble differs from the immediate.
// - skip_if_not_below skips when the nibble is unsigned greater or equal to the immediate.
// - skip_if_below skips when the nibble is unsigned less than the immediate.
// - the compare-skip ops ignore decimal and compare-only and never touch carry or zero.
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module nlts_core (
   input  wire logic                  clk_sys_in,
   input  wire logic                  rst_in,
   input  wire logic                  ce_in,
   input  wire nlts_pkg::nlts_wb_req_t wb_req_in,
   output logic [31:0]                wb_dat_out,
   output logic                       wb_ack_out,
   output logic                       skip_pending_out
);
   import nlts_pkg::*;

   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [31:0] byte_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  sel);
      logic [31:0] merged;
      merged = old_val;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            merged[b*8 +: 8] = new_val[b*8 +: 8];
         end
      end
      return merged;
   endfunction

   function automatic logic [3:0] word_index(input logic [7:0] adr,
                                             input logic [7:0] base);
      logic [7:0] diff;
      diff = adr - base;
      return diff[5:2];
   endfunction

   // ****************************************************
   // state
   // ****************************************************
   logic [3:0]  mem_reg [MEM_DEPTH];
   logic [3:0]  greg_reg [GREG_DEPTH];
   nlts_psw_t   psw_reg;
   logic [7:0]  pc_reg;
   logic        skip_pending_reg;
   logic        last_skip_reg;
   logic [3:0]  last_result_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;

   // ****************************************************
   // bus decode
   // ****************************************************
   logic        bus_go;
   logic        wr_go;
   logic        hit_instr;
   logic        hit_psw;
   logic        hit_status;
   logic        hit_mem;
   logic        hit_greg;
   logic [3:0]  mem_idx;
   logic [1:0]  greg_idx;

   assign bus_go  = ce_in && wb_req_in.cyc && wb_req_in.stb && !ack_reg;
   assign wr_go   = bus_go && wb_req_in.we;
   assign mem_idx = word_index(wb_req_in.adr, ADDR_MEM_BASE);
   assign greg_idx = 2'(word_index(wb_req_in.adr, ADDR_GREG_BASE));

   always_comb begin
      hit_instr  = 1'b0;
      hit_psw    = 1'b0;
      hit_status = 1'b0;
      hit_mem    = 1'b0;
      hit_greg   = 1'b0;
      if (wb_req_in.adr[1:0] != 2'h0) begin
         hit_instr = 1'b0;
      end else if (wb_req_in.adr == ADDR_INSTR) begin
         hit_instr = 1'b1;
      end else if (wb_req_in.adr == ADDR_PSW) begin
         hit_psw = 1'b1;
      end else if (wb_req_in.adr == ADDR_STATUS) begin
         hit_status = 1'b1;
      end else if (wb_req_in.adr >= ADDR_MEM_BASE && wb_req_in.adr <= ADDR_MEM_LAST) begin
         hit_mem = 1'b1;
      end else if (wb_req_in.adr >= ADDR_GREG_BASE && wb_req_in.adr <= ADDR_GREG_LAST) begin
         hit_greg = 1'b1;
      end
   end

   // ****************************************************
   // instruction decode and execution
   // ****************************************************
   nlts_instr_t instr;
   logic        exec_fire;
   logic        exec_live;
   logic [3:0]  eff_addr;
   logic [3:0]  mem_val;
   logic [3:0]  other_val;
   logic        use_greg;
   logic [3:0]  alu_result;
   logic        alu_stores;
   logic        alu_bit_test;
   logic        alu_skip;
   logic        is_compare;

   assign instr     = nlts_instr_t'(INSTR_W'(byte_merge(DATA_ZERO, wb_req_in.dat,
                                                        wb_req_in.sel)));
   assign exec_fire = wr_go && hit_instr && wb_req_in.sel[0];
   assign exec_live = exec_fire && !skip_pending_reg;
   assign eff_addr  = psw_reg.index_enable_flag ? 4'(instr.addr + psw_reg.index)
                                                : instr.addr;
   assign mem_val   = mem_reg[eff_addr];
   // register form exists for logic ops only
   assign use_greg  = instr.reg_form && alu_stores;
   assign other_val = use_greg ? greg_reg[instr.operand[1:0]] : instr.operand;
   assign is_compare = !alu_stores && !alu_bit_test && instr.op != OP_NOP &&
                       instr.op <= OP_SKIP_IF_BELOW;

   nlts_nibble_alu u_alu (
      .op_in           (instr.op),
      .mem_val_in      (mem_val),
      .other_val_in    (other_val),
      .result_out      (alu_result),
      .stores_out      (alu_stores),
      .is_bit_test_out (alu_bit_test),
      .skip_cond_out   (alu_skip)
   );

   // ****************************************************
   // data memory
   // ****************************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_reg[i] <= NIB_RESET;
         end
      end else if (exec_live && alu_stores && !use_greg) begin
         mem_reg[eff_addr] <= alu_result;
      end else if (wr_go && hit_mem) begin
         mem_reg[mem_idx] <= 4'(byte_merge({28'h0, mem_reg[mem_idx]}, wb_req_in.dat,
                                           wb_req_in.sel));
      end
   end

   // ****************************************************
   // general registers
   // ****************************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         for (int i = 0; i < GREG_DEPTH; i++) begin
            greg_reg[i] <= NIB_RESET;
         end
      end else if (exec_live && use_greg) begin
         greg_reg[instr.operand[1:0]] <= alu_result;
      end else if (wr_go && hit_greg) begin
         greg_reg[greg_idx] <= 4'(byte_merge({28'h0, greg_reg[greg_idx]}, wb_req_in.dat,
                                             wb_req_in.sel));
      end
   end

   // ****************************************************
   // program status word
   // ****************************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         psw_reg <= PSW_RESET;
      end else if (exec_live && alu_bit_test) begin
         psw_reg.compare_only_flag <= 1'b0;
      end else if (wr_go && hit_psw) begin
         psw_reg <= nlts_psw_t'(PSW_W'(byte_merge({23'h0, psw_reg}, wb_req_in.dat,
                                                  wb_req_in.sel)));
      end
   end

   // ****************************************************
   // program counter and skip
   // ****************************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pc_reg           <= PC_RESET;
         skip_pending_reg <= 1'b0;
         last_skip_reg    <= 1'b0;
         last_result_reg  <= NIB_RESET;
      end else if (exec_fire) begin
         pc_reg <= pc_reg + PC_STEP;
         if (skip_pending_reg) begin
            skip_pending_reg <= 1'b0;
            last_skip_reg    <= 1'b1;
         end else begin
            skip_pending_reg <= alu_skip;
            last_skip_reg    <= 1'b0;
            last_result_reg  <= alu_stores ? alu_result : mem_val;
         end
      end
   end

   assign skip_pending_out = skip_pending_reg;

   // ****************************************************
   // bus answer
   // ****************************************************
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ack_reg <= 1'b0;
      end else if (ce_in) begin
         ack_reg <= bus_go;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         dat_reg <= DATA_ZERO;
      end else if (bus_go) begin
         dat_reg <= DATA_ZERO;
         if (hit_psw) begin
            dat_reg <= {23'h0, psw_reg};
         end else if (hit_status) begin
            dat_reg[STAT_SKIP_BIT]                <= skip_pending_reg;
            dat_reg[STAT_LAST_BIT]                <= last_skip_reg;
            dat_reg[STAT_PC_LSB +: PC_W]          <= pc_reg;
            dat_reg[STAT_RESULT_LSB +: NIB_W]     <= last_result_reg;
         end else if (hit_mem) begin
            dat_reg[3:0] <= mem_reg[mem_idx];
         end else if (hit_greg) begin
            dat_reg[3:0] <= greg_reg[greg_idx];
         end
      end
   end

   assign wb_ack_out = ack_reg;
   assign wb_dat_out = dat_reg;

   // ****************************************************
   // checks
   // ****************************************************
   logic [3:0] chk_logic;
   always_comb begin
      chk_logic = mem_val ^ other_val;
      if (instr.op == OP_AND) begin
         chk_logic = mem_val & other_val;
      end else if (instr.op == OP_OR) begin
         chk_logic = mem_val | other_val;
      end
   end

   a_logic_store_mem: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && alu_stores && !instr.reg_form |=>
         mem_reg[$past(eff_addr)] == $past(chk_logic))
      else $error("logic result not stored in memory");

   a_logic_keep_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && alu_stores |=> $stable(psw_reg))
      else $error("logic op changed the status word");

   a_all_set_skip: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && instr.op == OP_SKIP_IF_ALL_SET |=>
         skip_pending_reg == (($past(mem_val) & $past(instr.operand)) == $past(instr.operand)))
      else $error("all-set test gave wrong skip");

   a_all_clr_skip: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && instr.op == OP_SKIP_IF_ALL_CLR |=>
         skip_pending_reg == (($past(mem_val) & $past(instr.operand)) == 4'h0))
      else $error("all-clear test gave wrong skip");

   a_test_clears_cmp: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && alu_bit_test |=> !psw_reg.compare_only_flag &&
         psw_reg.carry_flag == $past(psw_reg.carry_flag) &&
         psw_reg.zero_flag == $past(psw_reg.zero_flag))
      else $error("bit test flag handling wrong");

   a_index_address: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && psw_reg.index_enable_flag && alu_stores && !instr.reg_form |=>
         mem_reg[4'($past(instr.addr) + $past(psw_reg.index))] == $past(chk_logic))
      else $error("index modification not applied");

   a_equal_skip: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && instr.op == OP_SKIP_IF_EQUAL |=>
         skip_pending_reg == ($past(mem_val) == $past(instr.operand)))
      else $error("equal test gave wrong skip");

   a_unequal_skip: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && instr.op == OP_SKIP_IF_UNEQUAL |=>
         skip_pending_reg == ($past(mem_val) != $past(instr.operand)))
      else $error("unequal test gave wrong skip");

   a_order_skip: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && (instr.op == OP_SKIP_IF_NOT_BELOW || instr.op == OP_SKIP_IF_BELOW) |=>
         skip_pending_reg == (($past(mem_val) < $past(instr.operand)) ==
                              ($past(instr.op) == OP_SKIP_IF_BELOW)))
      else $error("ordered compare gave wrong skip");

   a_compare_flags: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_live && is_compare |=> $stable(psw_reg))
      else $error("compare changed the status word");

   a_skip_suppress: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      exec_fire && skip_pending_reg |=> !skip_pending_reg && $stable(psw_reg) &&
         pc_reg == 8'($past(pc_reg) + 8'h01) && mem_reg[$past(eff_addr)] == $past(mem_val))
      else $error("skipped instruction took effect");

endmodule
`default_nettype wire

// ---- hw/nlts_pkg.sv ----
// constants and types shared by the nibble logic and test-skip unit
package nlts_pkg;

   // ****************************************************
   // sizes
   // ****************************************************
   localparam int unsigned NIB_W      = 4;
   localparam int unsigned MEM_DEPTH  = 16;
   localparam int unsigned MEM_AW     = 4;
   localparam int unsigned GREG_DEPTH = 4;
   localparam int unsigned GREG_AW    = 2;
   localparam int unsigned PC_W       = 8;
   localparam int unsigned WB_AW      = 8;
   localparam int unsigned WB_DW      = 32;
   localparam int unsigned WB_SW      = 4;

   // ****************************************************
   // register offsets (byte addresses)
   // ****************************************************
   localparam logic [7:0] ADDR_INSTR     = 8'h00;
   localparam logic [7:0] ADDR_PSW       = 8'h04;
   localparam logic [7:0] ADDR_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_MEM_BASE  = 8'h40;
   localparam logic [7:0] ADDR_MEM_LAST  = 8'h7C;
   localparam logic [7:0] ADDR_GREG_BASE = 8'h80;
   localparam logic [7:0] ADDR_GREG_LAST = 8'h8C;

   // ****************************************************
   // field positions and widths
   // ****************************************************
   localparam int unsigned INSTR_W         = 13;
   localparam int unsigned PSW_W           = 9;
   localparam int unsigned STAT_SKIP_BIT   = 0;
   localparam int unsigned STAT_LAST_BIT   = 1;
   localparam int unsigned STAT_PC_LSB     = 8;
   localparam int unsigned STAT_RESULT_LSB = 16;

   // ****************************************************
   // types
   // ****************************************************
   typedef enum logic [3:0] {
      OP_AND              = 4'h0,
      OP_OR               = 4'h1,
      OP_XOR              = 4'h2,
      OP_SKIP_IF_ALL_SET  = 4'h3,
      OP_SKIP_IF_ALL_CLR  = 4'h4,
      OP_SKIP_IF_EQUAL    = 4'h5,
      OP_SKIP_IF_UNEQUAL  = 4'h6,
      OP_SKIP_IF_NOT_BELOW = 4'h7,
      OP_SKIP_IF_BELOW    = 4'h8,
      OP_NOP              = 4'hF
   } nlts_op_t;

   // bit 12 reg_form, 11:8 operand, 7:4 addr, 3:0 op
   typedef struct packed {
      logic             reg_form;
      logic [3:0]       operand;
      logic [3:0]       addr;
      nlts_op_t         op;
   } nlts_instr_t;

   // bit 0 zero, 1 carry, 2 compare-only, 3 decimal, 4 index enable, 8:5 index
   typedef struct packed {
      logic [3:0]       index;
      logic             index_enable_flag;
      logic             decimal_mode_flag;
      logic             compare_only_flag;
      logic             carry_flag;
      logic             zero_flag;
   } nlts_psw_t;

   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [7:0]       adr;
      logic [3:0]       sel;
      logic [31:0]      dat;
   } nlts_wb_req_t;

   // ****************************************************
   // reset values
   // ****************************************************
   localparam nlts_psw_t   PSW_RESET   = 9'h000;
   localparam logic [3:0]  NIB_RESET   = 4'h0;
   localparam logic [7:0]  PC_RESET    = 8'h00;
   localparam logic [7:0]  PC_STEP     = 8'h01;
   localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

endpackage

// ---- hw/nlts_nibble_alu.sv ----
// bitwise operations and skip conditions on one data-memory nibble
`timescale 1ns/1ps
`default_nettype none

module nlts_nibble_alu (
   input  wire nlts_pkg::nlts_op_t op_in,
   input  wire logic [3:0]         mem_val_in,
   input  wire logic [3:0]         other_val_in,
   output logic [3:0]              result_out,
   output logic                    stores_out,
   output logic                    is_bit_test_out,
   output logic                    skip_cond_out
);
   import nlts_pkg::*;

   // ****************************************************
   // logic ops and test conditions
   // ****************************************************
   always_comb begin
      result_out      = mem_val_in;
      stores_out      = 1'b0;
      is_bit_test_out = 1'b0;
      skip_cond_out   = 1'b0;
      case (op_in)
         OP_AND: begin
            result_out = mem_val_in & other_val_in;
            stores_out = 1'b1;
         end
         OP_OR: begin
            result_out = mem_val_in | other_val_in;
            stores_out = 1'b1;
         end
         OP_XOR: begin
            result_out = mem_val_in ^ other_val_in;
            stores_out = 1'b1;
         end
         OP_SKIP_IF_ALL_SET: begin
            is_bit_test_out = 1'b1;
            skip_cond_out   = (mem_val_in & other_val_in) == other_val_in;
         end
         OP_SKIP_IF_ALL_CLR: begin
            is_bit_test_out = 1'b1;
            skip_cond_out   = (mem_val_in & other_val_in) == NIB_RESET;
         end
         OP_SKIP_IF_EQUAL: begin
            skip_cond_out = mem_val_in == other_val_in;
         end
         OP_SKIP_IF_UNEQUAL: begin
            skip_cond_out = mem_val_in != other_val_in;
         end
         OP_SKIP_IF_NOT_BELOW: begin
            skip_cond_out = mem_val_in >= other_val_in;
         end
         OP_SKIP_IF_BELOW: begin
            skip_cond_out = mem_val_in < other_val_in;
         end
         default: begin
            result_out = mem_val_in;
         end
      endcase
   end

endmodule
`default_nettype wire

// ---- testbench/test_nlts_core.sv ----
// self-checking bench for the nibble logic and test-skip unit
`timescale 1ns/1ps
`default_nettype none

module test_nlts_core;
   import nlts_pkg::*;

   logic         clk_sys_in;
   logic         rst_in;
   logic         ce_in;
   nlts_wb_req_t wb_req_in;
   logic [31:0]  wb_dat_out;
   logic         wb_ack_out;
   logic         skip_pending_out;
   int           mismatches = 0;
   int           n_checks   = 0;
   int           cycles     = 0;
   logic [31:0]  rd;
   logic [7:0]   pc0;

   nlts_core u_dut (
      .clk_sys_in       (clk_sys_in),
      .rst_in           (rst_in),
      .ce_in            (ce_in),
      .wb_req_in        (wb_req_in),
      .wb_dat_out       (wb_dat_out),
      .wb_ack_out       (wb_ack_out),
      .skip_pending_out (skip_pending_out)
   );

   // ****************************************************
   // clock, timeout and verdict
   // ****************************************************
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ****************************************************
   // bus cycles and comparison
   // ****************************************************
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_req_in <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
      do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1);
      rd = wb_dat_out;
      wb_req_in <= '0;
      @(posedge clk_sys_in);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb_cycle(1'b1, adr, dat);
   endtask

   task automatic rdreg(input logic [7:0] adr);
      wb_cycle(1'b0, adr, 32'h0000_0000);
   endtask

   task automatic exec(input nlts_op_t op, input logic [3:0] adr, input logic [3:0] opnd,
                       input logic rf);
      nlts_instr_t ins;
      ins = '{reg_form: rf, operand: opnd, addr: adr, op: op};
      wr(ADDR_INSTR, {19'h0, ins});
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one test on memory nibble 3 with all four low flags set beforehand
   task automatic run_skip(input nlts_op_t op, input logic [3:0] m, input logic [3:0] imm,
                           input logic rf, input logic exp);
      logic [8:0] psw_exp;
      psw_exp = (op == OP_SKIP_IF_ALL_SET || op == OP_SKIP_IF_ALL_CLR) ? 9'h00B : 9'h00F;
      wr(8'h4C, {28'h000_0000, m});
      wr(ADDR_PSW, 32'h0000_000F);
      exec(op, 4'h3, imm, rf);
      check("skip_pending", {31'h0, exp}, {31'h0, skip_pending_out});
      rdreg(ADDR_PSW);
      check("psw_after_test", {23'h00_0000, psw_exp}, rd);
      exec(OP_NOP, 4'h0, 4'h0, 1'b0);
      check("skip_consumed", 32'h0000_0000, {31'h0, skip_pending_out});
   endtask

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic test_reset();
      rdreg(ADDR_PSW);
      check("psw_reset", 32'h0000_0000, rd);
      rdreg(ADDR_STATUS);
      check("status_reset", 32'h0000_0000, rd);
      wr(8'hF0, 32'hFFFF_FFFF);
      rdreg(8'hF0);
      check("unmapped_read", 32'h0000_0000, rd);
      $display("test_reset done");
   endtask

   task automatic test_logic();
      nlts_op_t   ops[3] = '{OP_AND, OP_OR, OP_XOR};
      logic [3:0] res[3] = '{4'h8, 4'hE, 4'h6};
      for (int i = 0; i < 3; i++) begin
         wr(8'h44, 32'h0000_000C);
         wr(ADDR_PSW, 32'h0000_000F);
         exec(ops[i], 4'h1, 4'hA, 1'b0);
         rdreg(8'h44);
         check("logic_result", {28'h000_0000, res[i]}, rd);
         rdreg(ADDR_PSW);
         check("logic_psw", 32'h0000_000F, rd);
      end
      wr(8'h84, 32'h0000_0005);
      exec(OP_OR, 4'h1, 4'h1, 1'b1);
      rdreg(8'h84);
      check("reg_form_result", 32'h0000_0007, rd);
      $display("test_logic done");
   endtask

   task automatic test_bits();
      run_skip(OP_SKIP_IF_ALL_SET, 4'hB, 4'hB, 1'b0, 1'b1);
      run_skip(OP_SKIP_IF_ALL_SET, 4'hB, 4'hD, 1'b0, 1'b0);
      run_skip(OP_SKIP_IF_ALL_CLR, 4'h9, 4'h6, 1'b1, 1'b1);
      run_skip(OP_SKIP_IF_ALL_CLR, 4'h9, 4'hE, 1'b0, 1'b0);
      $display("test_bits done");
   endtask

   task automatic test_compare();
      run_skip(OP_SKIP_IF_EQUAL, 4'hA, 4'hA, 1'b0, 1'b1);
      run_skip(OP_SKIP_IF_EQUAL, 4'hA, 4'h8, 1'b1, 1'b0);
      run_skip(OP_SKIP_IF_UNEQUAL, 4'hA, 4'h8, 1'b0, 1'b1);
      run_skip(OP_SKIP_IF_UNEQUAL, 4'hA, 4'hA, 1'b0, 1'b0);
      run_skip(OP_SKIP_IF_NOT_BELOW, 4'h8, 4'h7, 1'b0, 1'b1);
      run_skip(OP_SKIP_IF_NOT_BELOW, 4'h8, 4'h8, 1'b0, 1'b1);
      run_skip(OP_SKIP_IF_NOT_BELOW, 4'h8, 4'h9, 1'b0, 1'b0);
      run_skip(OP_SKIP_IF_BELOW, 4'h8, 4'h9, 1'b0, 1'b1);
      run_skip(OP_SKIP_IF_BELOW, 4'h8, 4'h8, 1'b0, 1'b0);
      run_skip(OP_SKIP_IF_BELOW, 4'h0, 4'hF, 1'b0, 1'b1);
      $display("test_compare done");
   endtask

   task automatic test_index();
      wr(8'h44, 32'h0000_000F);
      wr(8'h78, 32'h0000_0000);
      // index 3 enabled, address 14 wraps round to nibble 1
      wr(ADDR_PSW, 32'h0000_0070);
      exec(OP_SKIP_IF_ALL_SET, 4'hE, 4'hF, 1'b0);
      check("indexed_skip", 32'h0000_0001, {31'h0, skip_pending_out});
      exec(OP_NOP, 4'h0, 4'h0, 1'b0);
      exec(OP_XOR, 4'hE, 4'h5, 1'b0);
      rdreg(8'h44);
      check("indexed_logic", 32'h0000_000A, rd);
      rdreg(8'h78);
      check("unindexed_untouched", 32'h0000_0000, rd);
      wr(ADDR_PSW, 32'h0000_0000);
      $display("test_index done");
   endtask

   task automatic test_suppress();
      wr(8'h48, 32'h0000_0003);
      rdreg(ADDR_STATUS);
      pc0 = rd[15:8];
      exec(OP_SKIP_IF_EQUAL, 4'h2, 4'h3, 1'b0);
      exec(OP_XOR, 4'h2, 4'hF, 1'b0);
      rdreg(ADDR_STATUS);
      check("pc_advance", {24'h00_0000, pc0 + 8'h02}, {24'h00_0000, rd[15:8]});
      check("skip_status", 32'h0000_0002, {30'h0, rd[1:0]});
      rdreg(8'h48);
      check("suppressed_mem", 32'h0000_0003, rd);
      $display("test_suppress done");
   endtask

   // request held while the clock enable is low must wait, then land
   task automatic test_freeze();
      ce_in <= 1'b0;
      wb_req_in <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, adr: ADDR_PSW, sel: 4'hF,
                     dat: 32'h0000_0005};
      repeat (3) @(posedge clk_sys_in);
      check("frozen_ack", 32'h0000_0000, {31'h0, wb_ack_out});
      ce_in <= 1'b1;
      do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1);
      wb_req_in <= '0;
      @(posedge clk_sys_in);
      rdreg(ADDR_PSW);
      check("frozen_write", 32'h0000_0005, rd);
      $display("test_freeze done");
   endtask

   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      wb_req_in = '0;
      repeat (6) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      test_reset();
      test_logic();
      test_bits();
      test_compare();
      test_index();
      test_suppress();
      test_freeze();
      print_verdict();
   end

endmodule
`default_nettype wire
